// file: rtl/rtc_core_pkg.sv
// Constants shared by the reset, refresh and countdown core
package rtc_core_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned TICK32_HZ        = 32;
  localparam int unsigned TICK32_CYC       = CLK_HZ / TICK32_HZ;
  localparam int unsigned NV_CYCLE_MS      = 10;
  localparam int unsigned NV_BUSY_CYC      = (CLK_HZ / 1000) * NV_CYCLE_MS;
  localparam int unsigned REFRESH_PERIOD_S = 3600;
  localparam int unsigned WDT_SHORT_S      = 2;
  localparam int unsigned WDT_LONG_S       = 32;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MAIN_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h01;
  localparam logic [7:0] ADDR_IRQ_FLAGS  = 8'h02;
  localparam logic [7:0] ADDR_CTRL_STAT  = 8'h03;
  localparam logic [7:0] ADDR_RST_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_CNT_LOW    = 8'h18;
  localparam logic [7:0] ADDR_CNT_HIGH   = 8'h19;
  localparam logic [7:0] ADDR_NV_CTRL    = 8'h30;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MAIN_CTRL_RST = 8'h99;
  localparam logic [7:0] IRQ_EN_RST    = 8'h00;
  localparam logic [7:0] NV_CTRL_RST   = 8'h02;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_CLK_SEL     = 7;
  localparam int BIT_TICK_SEL_HI = 6;
  localparam int BIT_TICK_SEL_LO = 5;
  localparam int BIT_RECOV_EN    = 4;
  localparam int BIT_NV_REFRESH  = 3;
  localparam int BIT_AUTO_RELOAD = 2;
  localparam int BIT_CD_ENABLE   = 1;
  localparam int BIT_CD_IRQ_EN   = 1;
  localparam int BIT_RECOV_IRQ   = 4;
  localparam int BIT_CD_FLAG     = 1;
  localparam int BIT_NV_BUSY     = 7;
  localparam int BIT_POWER_ON    = 5;
  localparam int BIT_SYS_RESET   = 4;
  localparam int BIT_SOFT_RST    = 4;
  localparam int BIT_MON_PERIOD  = 0;

  // Tick source codes
  localparam logic [1:0] TSEL_32HZ   = 2'h0;
  localparam logic [1:0] TSEL_8HZ    = 2'h1;
  localparam logic [1:0] TSEL_1HZ    = 2'h2;
  localparam logic [1:0] TSEL_HALFHZ = 2'h3;

  typedef enum logic [0:0] {NV_IDLE, NV_BUSY} nv_state_t;

endpackage : rtc_core_pkg

// file: rtl/rtc_tick_divider.sv
// Divider producing the 32, 8, 1 and 0.5 Hz tick strobes
`timescale 1ns/1ps
module rtc_tick_divider #(
  parameter int unsigned TICK_DIV = 312500
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  output logic      o_t32_ff,
  output logic      o_t8_ff,
  output logic      o_t1_ff,
  output logic      o_thalf_ff
);
  localparam int DW = $clog2(TICK_DIV);

  if (TICK_DIV < 2) begin : g_chk
    $error("TICK_DIV must be at least 2");
  end

  logic [DW-1:0] div_ff, nxt_div;
  logic [5:0]    sub_ff, nxt_sub;
  logic          nxt_t32, nxt_t8, nxt_t1, nxt_thalf;

  always_comb begin
    nxt_div   = div_ff + 1'b1;
    nxt_sub   = sub_ff;
    nxt_t32   = 1'b0;
    nxt_t8    = 1'b0;
    nxt_t1    = 1'b0;
    nxt_thalf = 1'b0;
    if (div_ff == DW'(TICK_DIV - 1)) begin
      nxt_div   = '0;
      nxt_sub   = sub_ff + 1'b1;
      nxt_t32   = 1'b1;
      nxt_t8    = (sub_ff[1:0] == 2'h3);
      nxt_t1    = (sub_ff[4:0] == 5'h1F);
      nxt_thalf = (sub_ff == 6'h3F);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      div_ff     <= '0;
      sub_ff     <= 6'h00;
      o_t32_ff   <= 1'b0;
      o_t8_ff    <= 1'b0;
      o_t1_ff    <= 1'b0;
      o_thalf_ff <= 1'b0;
    end else begin
      div_ff     <= nxt_div;
      sub_ff     <= nxt_sub;
      o_t32_ff   <= nxt_t32;
      o_t8_ff    <= nxt_t8;
      o_t1_ff    <= nxt_t1;
      o_thalf_ff <= nxt_thalf;
    end
  end

endmodule : rtc_tick_divider

// file: rtl/rtc_recovery_watchdog.sv
// Deadlock watchdog: counts seconds since the last heartbeat
`timescale 1ns/1ps
module rtc_recovery_watchdog import rtc_core_pkg::*; (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_tick_1hz,
  input  wire logic i_kick,
  input  wire logic i_enable,
  input  wire logic i_long_period,
  input  wire logic i_clear,
  output logic      o_fire_ff
);
  logic [5:0] sec_ff, nxt_sec;
  logic [5:0] limit;
  logic       nxt_fire;

  always_comb begin
    limit    = i_long_period ? 6'(WDT_LONG_S) : 6'(WDT_SHORT_S);
    nxt_sec  = sec_ff;
    nxt_fire = 1'b0;
    // A kick or a system reset restarts the window
    if (i_kick || i_clear || !i_enable) begin
      nxt_sec = 6'h00;
    end else if (i_tick_1hz) begin
      if (sec_ff + 6'h01 >= limit) begin
        nxt_sec  = 6'h00;
        nxt_fire = 1'b1;
      end else begin
        nxt_sec = sec_ff + 6'h01;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sec_ff    <= 6'h00;
      o_fire_ff <= 1'b0;
    end else begin
      sec_ff    <= nxt_sec;
      o_fire_ff <= nxt_fire;
    end
  end

endmodule : rtc_recovery_watchdog

// file: rtl/rtc_reset_timer_core.sv
// Reset sources, register reset values, NV refresh and countdown timer
//
// Function
// - Power-on reset sets power_on_flag; stays until host writes zero.
// - Writing soft_reset_cmd one runs a system reset and sets sys_reset_flag.
// - After any reset recovery_enable reads one, recovery_irq_enable zero.
// - Watchdog reset sets sys_reset_flag and recovery_irq_flag; cleared by zero.
// - Recovery reset drives the interrupt only with recovery_irq_enable set.
// - Unkicked watchdog resets within one monitor period, 2 or 32 s.
// - Countdown value registers survive every system reset.
// - nv_control survives every system reset; only host writes change it.
// - After reset timer and auto_reload off, tick source 32 Hz.
// - After reset clock out, alarms and interrupts off, recovery, refresh on.
// - With nv_refresh_enable set, NV pages refresh once per hour.
// - nv_busy is one during a NV write or refresh cycle.
// - countdown_enable bit gates the countdown.
// - Tick select codes give 32, 8, 1 and 0.5 Hz.
// - Count down one per tick from 16-bit value; zero ends; zero loaded stops.
// - auto_reload reloads the value at each end and restarts.
// - Reload costs one tick: first period n, later periods n+1.
// - With timer irq enabled, countdown_flag sets at every countdown end.
// - Active-low interrupt follows countdown_flag; released when it clears.
// - Tick select and auto_reload writable only while timer disabled.
// - Countdown value writable only with timer and auto_reload off.
`timescale 1ns/1ps
module rtc_reset_timer_core import rtc_core_pkg::*; #(
  parameter int unsigned TICK_DIV   = TICK32_CYC,
  parameter int unsigned NV_CYC     = NV_BUSY_CYC,
  parameter int unsigned REFRESH_S  = REFRESH_PERIOD_S,
  parameter logic [7:0]  NV_FACTORY = NV_CTRL_RST
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_ctrl_alive,
  input  wire logic       i_int_pin,
  output logic      [7:0] o_rdata_ff,
  output logic            o_int_out_ff,
  output logic            o_int_oe_n_ff,
  output logic            o_sys_reset_ff
);
  localparam int BW = $clog2(NV_CYC + 1);

  if (NV_CYC < 1 || REFRESH_S < 1 || REFRESH_S > 4095) begin : g_chk
    $error("NV_CYC or REFRESH_S out of range");
  end

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  main_ctrl_ff, nxt_main_ctrl;
  logic [4:0]  irq_en_ff, nxt_irq_en;
  logic        cd_flag_ff, nxt_cd_flag;
  logic        recov_flag_ff, nxt_recov_flag;
  logic        pon_ff, nxt_pon;
  logic        sr_ff, nxt_sr;
  logic        soft_cmd_ff, nxt_soft_cmd;
  logic [7:0]  cnt_low_ff, nxt_cnt_low;
  logic [7:0]  cnt_high_ff, nxt_cnt_high;
  logic [7:0]  nv_ctrl_ff, nxt_nv_ctrl;
  logic [15:0] cd_ff, nxt_cd;
  logic [11:0] hour_ff, nxt_hour;
  logic [BW-1:0] busy_ff, nxt_busy;
  nv_state_t   nv_st_ff, nxt_nv_st;
  logic [7:0]  nxt_rdata;

  logic t32, t8, t1, thalf, tick, wdt_fire, sys_rst_req, cd_end;
  logic [15:0] reload_val;
  logic [1:0]  tsel;
  logic        cd_en, auto_rl, int_cond;

  assign cd_en       = main_ctrl_ff[BIT_CD_ENABLE];
  assign auto_rl     = main_ctrl_ff[BIT_AUTO_RELOAD];
  assign tsel        = main_ctrl_ff[BIT_TICK_SEL_HI:BIT_TICK_SEL_LO];
  assign reload_val  = {cnt_high_ff, cnt_low_ff};
  assign sys_rst_req = soft_cmd_ff | wdt_fire;
  assign int_cond    = cd_flag_ff |
                       (recov_flag_ff & irq_en_ff[BIT_RECOV_IRQ]);

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  rtc_tick_divider #(.TICK_DIV(TICK_DIV)) u_div (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .o_t32_ff   (t32),
    .o_t8_ff    (t8),
    .o_t1_ff    (t1),
    .o_thalf_ff (thalf)
  );

  rtc_recovery_watchdog u_wdt (
    .i_mclk        (i_mclk),
    .i_rst_n       (i_rst_n),
    .i_tick_1hz    (t1),
    .i_kick        (i_ctrl_alive),
    .i_enable      (main_ctrl_ff[BIT_RECOV_EN]),
    .i_long_period (nv_ctrl_ff[BIT_MON_PERIOD]),
    .i_clear       (soft_cmd_ff),
    .o_fire_ff     (wdt_fire)
  );

  always_comb begin
    case (tsel)
      TSEL_32HZ: tick = t32;
      TSEL_8HZ:  tick = t8;
      TSEL_1HZ:  tick = t1;
      default:   tick = thalf;
    endcase
  end

  // ----------------------------------------------------------------
  // Register and timer next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_main_ctrl  = main_ctrl_ff;
    nxt_irq_en     = irq_en_ff;
    nxt_cd_flag    = cd_flag_ff;
    nxt_recov_flag = recov_flag_ff;
    nxt_pon        = pon_ff;
    nxt_sr         = sr_ff;
    nxt_soft_cmd   = soft_cmd_ff;
    nxt_cnt_low    = cnt_low_ff;
    nxt_cnt_high   = cnt_high_ff;
    nxt_nv_ctrl    = nv_ctrl_ff;
    nxt_cd         = cd_ff;
    cd_end         = 1'b0;

    if (i_wr) begin
      if (hit(i_addr, ADDR_MAIN_CTRL)) begin
        nxt_main_ctrl = i_wdata;
        if (cd_en) begin
          nxt_main_ctrl[BIT_TICK_SEL_HI] = main_ctrl_ff[BIT_TICK_SEL_HI];
          nxt_main_ctrl[BIT_TICK_SEL_LO] = main_ctrl_ff[BIT_TICK_SEL_LO];
          nxt_main_ctrl[BIT_AUTO_RELOAD] = auto_rl;
        end
      end
      if (hit(i_addr, ADDR_IRQ_EN)) begin
        nxt_irq_en = i_wdata[4:0];
      end
      if (hit(i_addr, ADDR_IRQ_FLAGS)) begin
        nxt_cd_flag    = cd_flag_ff & i_wdata[BIT_CD_FLAG];
        nxt_recov_flag = recov_flag_ff & i_wdata[BIT_RECOV_IRQ];
      end
      if (hit(i_addr, ADDR_CTRL_STAT)) begin
        nxt_pon = pon_ff & i_wdata[BIT_POWER_ON];
        nxt_sr  = sr_ff & i_wdata[BIT_SYS_RESET];
      end
      if (hit(i_addr, ADDR_RST_CTRL)) begin
        nxt_soft_cmd = i_wdata[BIT_SOFT_RST];
      end
      if (!cd_en && !auto_rl) begin
        if (hit(i_addr, ADDR_CNT_LOW)) begin
          nxt_cnt_low = i_wdata;
        end
        if (hit(i_addr, ADDR_CNT_HIGH)) begin
          nxt_cnt_high = i_wdata;
        end
      end
      if (hit(i_addr, ADDR_NV_CTRL)) begin
        nxt_nv_ctrl = i_wdata;
      end
    end

    // Stopped timer tracks the programmed value so enabling starts at n
    if (!cd_en) begin
      nxt_cd = reload_val;
    end else if (tick) begin
      if (cd_ff > 16'h0001) begin
        nxt_cd = cd_ff - 16'h0001;
      end else if (cd_ff == 16'h0001) begin
        nxt_cd = 16'h0000;
        cd_end = 1'b1;
      end else if (auto_rl && reload_val != 16'h0000) begin
        nxt_cd = reload_val;
      end
    end

    // Set beats a same-cycle clear
    if (cd_end && irq_en_ff[BIT_CD_IRQ_EN]) begin
      nxt_cd_flag = 1'b1;
    end

    // System reset: control registers only; data and NV bytes stay
    if (sys_rst_req) begin
      nxt_main_ctrl  = MAIN_CTRL_RST;
      nxt_irq_en     = IRQ_EN_RST[4:0];
      nxt_cd_flag    = 1'b0;
      nxt_recov_flag = wdt_fire;
      nxt_sr         = 1'b1;
      nxt_soft_cmd   = 1'b0;
      nxt_cd         = reload_val;
    end
  end

  // ----------------------------------------------------------------
  // NV refresh and busy
  // ----------------------------------------------------------------
  always_comb begin
    nxt_nv_st = nv_st_ff;
    nxt_busy  = busy_ff;
    nxt_hour  = hour_ff;
    if (t1) begin
      nxt_hour = (hour_ff == 12'(REFRESH_S - 1)) ? 12'h000
                                                 : hour_ff + 12'h001;
    end
    case (nv_st_ff)
      NV_IDLE: begin
        if ((i_wr && hit(i_addr, ADDR_NV_CTRL)) ||
            (t1 && hour_ff == 12'(REFRESH_S - 1) &&
             main_ctrl_ff[BIT_NV_REFRESH])) begin
          nxt_nv_st = NV_BUSY;
          nxt_busy  = BW'(NV_CYC - 1);
        end
      end
      NV_BUSY: begin
        if (busy_ff == '0) begin
          nxt_nv_st = NV_IDLE;
        end else begin
          nxt_busy = busy_ff - 1'b1;
        end
      end
      default: nxt_nv_st = NV_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = o_rdata_ff;
    if (i_rd) begin
      case (i_addr)
        ADDR_MAIN_CTRL: nxt_rdata = main_ctrl_ff;
        ADDR_IRQ_EN:    nxt_rdata = {3'h0, irq_en_ff};
        ADDR_IRQ_FLAGS: nxt_rdata = {3'h0, recov_flag_ff, 2'h0,
                                     cd_flag_ff, 1'b0};
        ADDR_CTRL_STAT: nxt_rdata = {nv_st_ff == NV_BUSY, 1'b0, pon_ff,
                                     sr_ff, 4'h0};
        ADDR_RST_CTRL:  nxt_rdata = {3'h0, soft_cmd_ff, 4'h0};
        ADDR_CNT_LOW:   nxt_rdata = cnt_low_ff;
        ADDR_CNT_HIGH:  nxt_rdata = cnt_high_ff;
        ADDR_NV_CTRL:   nxt_rdata = nv_ctrl_ff;
        default:        nxt_rdata = 8'h00;
      endcase
    end
  end

  // Power-on reset is the only event that loads the NV byte and POWER_ON_FLAG
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      main_ctrl_ff   <= MAIN_CTRL_RST;
      irq_en_ff      <= IRQ_EN_RST[4:0];
      cd_flag_ff     <= 1'b0;
      recov_flag_ff  <= 1'b0;
      pon_ff         <= 1'b1;
      sr_ff          <= 1'b0;
      soft_cmd_ff    <= 1'b0;
      cnt_low_ff     <= 8'h00;
      cnt_high_ff    <= 8'h00;
      nv_ctrl_ff     <= NV_FACTORY;
      cd_ff          <= 16'h0000;
      hour_ff        <= 12'h000;
      busy_ff        <= '0;
      nv_st_ff       <= NV_IDLE;
      o_rdata_ff     <= 8'h00;
      o_int_out_ff   <= 1'b0;
      o_int_oe_n_ff  <= 1'b1;
      o_sys_reset_ff <= 1'b0;
    end else begin
      main_ctrl_ff   <= nxt_main_ctrl;
      irq_en_ff      <= nxt_irq_en;
      cd_flag_ff     <= nxt_cd_flag;
      recov_flag_ff  <= nxt_recov_flag;
      pon_ff         <= nxt_pon;
      sr_ff          <= nxt_sr;
      soft_cmd_ff    <= nxt_soft_cmd;
      cnt_low_ff     <= nxt_cnt_low;
      cnt_high_ff    <= nxt_cnt_high;
      nv_ctrl_ff     <= nxt_nv_ctrl;
      cd_ff          <= nxt_cd;
      hour_ff        <= nxt_hour;
      busy_ff        <= nxt_busy;
      nv_st_ff       <= nxt_nv_st;
      o_rdata_ff     <= nxt_rdata;
      o_int_out_ff   <= 1'b0;
      o_int_oe_n_ff  <= !int_cond;
      o_sys_reset_ff <= sys_rst_req;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_pon_after_por: assert property ($rose(i_rst_n) |-> pon_ff)
    else $error("power_on_flag not set after power-on");
  a_soft_rst_load: assert property (soft_cmd_ff |=>
    (main_ctrl_ff == MAIN_CTRL_RST && sr_ff && !soft_cmd_ff &&
     irq_en_ff == 5'h00))
    else $error("soft reset did not load reset values");
  a_recov_flag_set: assert property (wdt_fire |=>
    (recov_flag_ff && sr_ff && !irq_en_ff[BIT_RECOV_IRQ]))
    else $error("recovery reset flags wrong");
  a_recov_int_gate: assert property ((recov_flag_ff &&
    !irq_en_ff[BIT_RECOV_IRQ] && !cd_flag_ff) |=> o_int_oe_n_ff)
    else $error("interrupt driven with recovery irq disabled");
  a_cd_end_flag: assert property ((cd_en && tick &&
    cd_ff == 16'h0001 && irq_en_ff[BIT_CD_IRQ_EN] && !sys_rst_req) |=>
    (cd_flag_ff && cd_ff == 16'h0000))
    else $error("countdown end did not set flag");
  a_cd_reload: assert property ((cd_en && auto_rl && tick &&
    cd_ff == 16'h0000 && reload_val != 16'h0000 && !sys_rst_req)
    |=> cd_ff == $past(reload_val))
    else $error("auto reload did not restore value");
  a_int_follow: assert property (cd_flag_ff |=> !o_int_oe_n_ff)
    else $error("interrupt not following countdown_flag");
  a_sel_locked: assert property ((cd_en && i_wr && !sys_rst_req &&
    i_addr == ADDR_MAIN_CTRL) |=> ($stable(tsel) && $stable(auto_rl)))
    else $error("tick select changed while running");
  a_cnt_locked: assert property (((cd_en || auto_rl) && i_wr)
    |=> ($stable(cnt_low_ff) && $stable(cnt_high_ff)))
    else $error("countdown value written while locked");
  a_nv_keep: assert property ((sys_rst_req &&
    !(i_wr && i_addr == ADDR_NV_CTRL)) |=> $stable(nv_ctrl_ff))
    else $error("nv_control changed by system reset");
  a_busy_start: assert property ((nv_st_ff == NV_IDLE && i_wr &&
    i_addr == ADDR_NV_CTRL) |=> nv_st_ff == NV_BUSY [*2])
    else $error("nv_busy not raised by NV write");

  c_soft_reset: cover property (soft_cmd_ff ##1 sr_ff);
  c_wdt_reset:  cover property (wdt_fire ##1 recov_flag_ff);
  c_cd_end:     cover property (cd_end ##1 !o_int_oe_n_ff);
  c_refresh:    cover property (t1 && nv_st_ff == NV_IDLE ##1
                                nv_st_ff == NV_BUSY);

endmodule : rtc_reset_timer_core

// file: tb/rtc_host_model.sv
// Host model driving the byte-wide register port
`timescale 1ns/1ps
module rtc_host_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 8'hA5;
    o_wdata = 8'h5A;
  end

  // Released lines show the inverse so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_addr  = a;
    o_wdata = d;
    o_wr    = 1'b1;
    @(posedge i_mclk);
    #1;
    o_wr    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
    // One idle edge keeps the next request out of this time step
    @(posedge i_mclk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_addr = a;
    o_rd   = 1'b1;
    @(posedge i_mclk);
    #1;
    o_rd   = 1'b0;
    o_addr = ~a;
    @(posedge i_mclk);
    #1;
    d      = i_rdata;
  endtask : rd

  task automatic poll;
    logic [7:0] s;
    s = 8'h80;
    for (int k = 0; k < 50 && s[7] !== 1'b0; k++) rd(8'h03, s);
  endtask : poll

  // Returns the status seen right after the write, for the busy check
  task automatic nv_wr(input logic [7:0] d, input int gap,
                       output logic [7:0] st);
    wr(8'h00, 8'h91);
    poll();
    wr(8'h30, d);
    rd(8'h03, st);
    repeat (gap) @(posedge i_mclk);
    #1;
    poll();
    wr(8'h00, 8'h99);
  endtask : nv_wr
endmodule : rtc_host_model

// file: tb/rtc_reset_and_countdown_timer_test.sv
// Self-checking bench for the reset, refresh and countdown core
`timescale 1ns/1ps
module rtc_reset_and_countdown_timer_test;
  localparam int TD  = 4;
  localparam int NVC = 5;
  localparam int SEC = 32 * TD;
  localparam int FAC [4] = '{1, 4, 32, 64};
  typedef struct {logic [7:0] a; logic [7:0] e;} row_t;
  row_t rows [15] = '{'{8'h00, 8'h99}, '{8'h01, 8'h00}, '{8'h02, 8'h00},
    '{8'h03, 8'h20}, '{8'h04, 8'h00}, '{8'h18, 8'h00}, '{8'h19, 8'h00},
    '{8'h30, 8'h02}, '{8'h05, 8'h00}, '{8'h00, 8'h99}, '{8'h01, 8'h00},
    '{8'h02, 8'h00}, '{8'h03, 8'h30}, '{8'h04, 8'h00}, '{8'h18, 8'h03}};
  logic       mclk;
  logic       rst_n;
  logic       alive;
  logic       kick;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] v;
  logic       int_out;
  logic       oe_n;
  logic       sys_rst;
  wire        int_pin;
  int         miscompares;
  int         compares;
  int         cyc;
  int         t0;
  int         n;

  // Open-drain wire with pull-up
  assign int_pin = oe_n ? 1'b1 : int_out;

  rtc_reset_timer_core #(.TICK_DIV(TD), .NV_CYC(NVC), .REFRESH_S(3),
    .NV_FACTORY(8'h02)) i_rtc_reset_timer_core (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .i_ctrl_alive(alive), .i_int_pin(int_pin),
    .o_rdata_ff(rdata), .o_int_out_ff(int_out), .o_int_oe_n_ff(oe_n),
    .o_sys_reset_ff(sys_rst));

  rtc_host_model i_rtc_host_model (.i_mclk(mclk), .i_rdata(rdata),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));

  always #50 mclk = ~mclk;
  // Heartbeat every 64 cycles keeps the watchdog quiet
  always @(posedge mclk) alive <= #1 kick && (cyc % 64) == 0;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      results();
    end
  end

  // ----
  // Checking helpers
  // ----
  task automatic chk(input string s, input logic [15:0] g,
                     input logic [15:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : chk

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_rtc_host_model.wr(a, d);
  endtask : w

  // Busy bit is masked: refresh may run at any time
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_rtc_host_model.rd(a, d);
    if (a == 8'h03) d[7] = 1'b0;
    chk($sformatf("reg %h", a), {8'h00, d}, {8'h00, e});
  endtask : rc

  task automatic pass(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : pass

  task automatic waitf;
    for (int k = 0; k < 3000 && oe_n !== 1'b0; k++) pass(1);
  endtask : waitf

  task automatic results;
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // ----
  // Main sequence
  // ----
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    kick = 1'b1;
    pass(2);
    rst_n = 1'b1;
    for (int r = 0; r < 9; r++) rc(rows[r].a, rows[r].e);
    w(8'h18, 8'h03);
    w(8'h19, 8'h00);
    w(8'h01, 8'h02);
    for (int c = 0; c < 4; c++) begin
      w(8'h00, 8'h91);
      w(8'h00, 8'h95 | 8'(c << 5));
      w(8'h02, 8'h00);
      w(8'h00, 8'h97 | 8'(c << 5));
      waitf();
      t0 = int'($time);
      w(8'h02, 8'h00);
      pass(3);
      chk("int", oe_n, 1);
      waitf();
      chk("period", 16'((int'($time) - t0) / 100), 16'(4 * TD * FAC[c]));
    end
    w(8'h18, 8'h07);
    w(8'h00, 8'h93);
    rc(8'h00, 8'hF7);
    rc(8'h18, 8'h03);
    w(8'h00, 8'h91);
    w(8'h02, 8'h00);
    pass(1100);
    rc(8'h02, 8'h00);
    w(8'h04, 8'h10);
    for (int k = 0; k < 4 && sys_rst !== 1'b1; k++) pass(1);
    chk("sysrst", sys_rst, 1);
    pass(1);
    chk("sysrst", sys_rst, 0);
    for (int r = 9; r < 15; r++) rc(rows[r].a, rows[r].e);
    w(8'h03, 8'h00);
    rc(8'h03, 8'h00);
    v = 8'h00;
    for (int k = 0; k < 300 && v[7] !== 1'b1; k++)
      i_rtc_host_model.rd(8'h03, v);
    chk("refresh", v[7], 1);
    for (int p = 1; p >= 0; p--) begin
      i_rtc_host_model.nv_wr(8'h02 | 8'(p), NVC, v);
      chk("busy", v[7], 1);
      rc(8'h30, 8'h02 | 8'(p));
      kick = 1'b0;
      for (n = 0; n < 5000 && sys_rst !== 1'b1; n++) pass(1);
      chk("wdt", 16'(n > (p ? 31 : 1) * SEC - 64 && n <= (p ? 32 : 2) * SEC + 8), 1);
      kick = 1'b1;
      rc(8'h02, 8'h10);
      rc(8'h03, 8'h10);
      rc(8'h30, 8'h02 | 8'(p));
      chk("int", oe_n, 1);
      w(8'h01, 8'h10);
      pass(2);
      chk("int", oe_n, 0);
      chk("pin", int_pin, 0);
      w(8'h02, 8'h00);
      w(8'h03, 8'h00);
      pass(2);
      chk("int", oe_n, 1);
    end
    results();
  end
endmodule : rtc_reset_and_countdown_timer_test
